// [src/bbx_dec_if.sv]
`default_nettype none
interface bbx_dec_if;
    logic [15:0] instr;
    bbx_pkg::bbx_kind_type kind;
    logic [2:0] bit_no;
    logic bank_sel;
    logic [7:0] file_addr;
    logic [7:0] off8;
    logic [10:0] off11;

    modport dec (
        input instr,
        output kind,
        output bit_no,
        output bank_sel,
        output file_addr,
        output off8,
        output off11
    );

    modport exec (
        output instr,
        input kind,
        input bit_no,
        input bank_sel,
        input file_addr,
        input off8,
        input off11
    );
endinterface
`default_nettype wire

// [src/bbx_decode.sv]
`default_nettype none
module bbx_decode (
    bbx_dec_if.dec d
);

    // ------------------------------------------------------------
    // opcode match
    // ------------------------------------------------------------
    always_comb begin
        d.kind = bbx_pkg::BBX_NONE;
        if (d.instr[bbx_pkg::COND_OP_MSB:bbx_pkg::COND_OP_LSB] == bbx_pkg::OP_BR_NOT_ZERO) begin
            d.kind = bbx_pkg::BBX_BR_NZ;
        end else if (d.instr[bbx_pkg::COND_OP_MSB:bbx_pkg::COND_OP_LSB] == bbx_pkg::OP_BR_NOT_OVF) begin
            d.kind = bbx_pkg::BBX_BR_NOV;
        end else if (d.instr[bbx_pkg::COND_OP_MSB:bbx_pkg::ALW_OP_LSB] == bbx_pkg::OP_BR_ALWAYS) begin
            d.kind = bbx_pkg::BBX_BR_ALW;
        end else if (d.instr[bbx_pkg::COND_OP_MSB:bbx_pkg::SET_OP_LSB] == bbx_pkg::OP_SET_BIT) begin
            d.kind = bbx_pkg::BBX_SET_BIT;
        end
    end

    // ------------------------------------------------------------
    // operand fields
    // ------------------------------------------------------------
    assign d.bit_no = d.instr[bbx_pkg::BIT_NO_MSB:bbx_pkg::BIT_NO_LSB];
    assign d.bank_sel = d.instr[bbx_pkg::BANK_SEL_POS];
    assign d.file_addr = d.instr[bbx_pkg::FILE_MSB:0];
    assign d.off8 = d.instr[bbx_pkg::OFF8_MSB:0];
    assign d.off11 = d.instr[bbx_pkg::OFF11_MSB:0];

endmodule
`default_nettype wire

// [src/bbx_exec.sv]
`default_nettype none
module bbx_exec #(
    parameter int PC_W = 21
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [PC_W-1:0] pc_next_i,
    input wire logic zero_flag_i,
    input wire logic ovf_flag_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic ext_set_en_i,
    input wire logic [bbx_pkg::DADDR_W-1:0] index_base_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [1:0] q_phase_o,
    output logic accept_o,
    output logic illegal_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_target_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [bbx_pkg::DADDR_W-1:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic status_we_o,
    output logic discard_o,
    output logic done_o
);

    // ------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------
    bbx_dec_if dec_bus ();

    bbx_decode u_dec (
        .d(dec_bus)
    );

    // ------------------------------------------------------------
    // registers and internal nets
    // ------------------------------------------------------------
    logic [1:0] q_q;
    bbx_pkg::bbx_state_type state_q;
    logic [PC_W-1:0] off_x2_q;
    logic [7:0] bit_mask_q;
    bbx_pkg::bbx_kind_type kind_q;
    logic take_q;
    logic [7:0] rd_data_q;
    logic pc_load_q;
    logic [PC_W-1:0] pc_target_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic [bbx_pkg::DADDR_W-1:0] mem_addr_q;
    logic [7:0] mem_wdata_q;
    logic accept_q;
    logic illegal_q;
    logic discard_q;
    logic done_q;
    logic status_we_q;

    logic accept_now;
    logic [bbx_pkg::DADDR_W-1:0] file_daddr;
    logic [PC_W-1:0] off_x2;

    // ------------------------------------------------------------
    // operand helpers
    // ------------------------------------------------------------
    // one-hot mask of the bit that a set-bit word names
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        logic [7:0] mask;
        mask = 8'h00;
        mask[pos] = 1'b1;
        return mask;
    endfunction

    // branch condition of a freshly decoded word, flags as sampled in Q1
    function automatic logic branch_taken(input bbx_pkg::bbx_kind_type kind, input logic zero_f,
        input logic ovf_f);
        logic taken;
        taken = 1'b0;
        case (kind)
            bbx_pkg::BBX_BR_NZ: taken = ~zero_f;
            bbx_pkg::BBX_BR_NOV: taken = ~ovf_f;
            bbx_pkg::BBX_BR_ALW: taken = 1'b1;
            default: taken = 1'b0;
        endcase
        return taken;
    endfunction

    assign dec_bus.instr = instr_i;
    assign accept_now = (q_q == bbx_pkg::Q1) && instr_valid_i && (state_q != bbx_pkg::BBX_ST_NOP);

    // ------------------------------------------------------------
    // quarter phase counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q_q <= bbx_pkg::Q1;
        end else begin
            q_q <= q_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // file register address resolution
    // ------------------------------------------------------------
    always_comb begin
        if (dec_bus.bank_sel) begin
            file_daddr = {bank_select_register_i, dec_bus.file_addr};
        end else if (ext_set_en_i && (dec_bus.file_addr <= bbx_pkg::INDEXED_MAX)) begin
            file_daddr = index_base_i + {4'h0, dec_bus.file_addr};
        end else if (dec_bus.file_addr < bbx_pkg::ACCESS_SPLIT) begin
            file_daddr = {bbx_pkg::ACCESS_LOW_BANK, dec_bus.file_addr};
        end else begin
            file_daddr = {bbx_pkg::ACCESS_HIGH_BANK, dec_bus.file_addr};
        end
    end

    // ------------------------------------------------------------
    // doubled signed offset, sign-extended to the counter width
    // ------------------------------------------------------------
    always_comb begin
        if (dec_bus.kind == bbx_pkg::BBX_BR_ALW) begin
            off_x2 = {{(PC_W-12){dec_bus.off11[bbx_pkg::OFF11_MSB]}}, dec_bus.off11, 1'b0};
        end else begin
            off_x2 = {{(PC_W-9){dec_bus.off8[bbx_pkg::OFF8_MSB]}}, dec_bus.off8, 1'b0};
        end
    end

    // ------------------------------------------------------------
    // instruction cycle sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= bbx_pkg::BBX_ST_IDLE;
        end else begin
            case (state_q)
                bbx_pkg::BBX_ST_IDLE: begin
                    if (accept_now && (dec_bus.kind != bbx_pkg::BBX_NONE)) begin
                        state_q <= bbx_pkg::BBX_ST_EXEC;
                    end
                end
                bbx_pkg::BBX_ST_EXEC: begin
                    if (q_q == bbx_pkg::Q4) begin
                        // taken branch spends a whole extra cycle doing nothing
                        state_q <= take_q ? bbx_pkg::BBX_ST_NOP : bbx_pkg::BBX_ST_IDLE;
                    end
                end
                bbx_pkg::BBX_ST_NOP: begin
                    if (q_q == bbx_pkg::Q4) begin
                        state_q <= bbx_pkg::BBX_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= bbx_pkg::BBX_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // instruction latch and branch condition at end of Q1
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            off_x2_q <= '0;
            bit_mask_q <= bbx_pkg::DATA_RESET;
            kind_q <= bbx_pkg::BBX_NONE;
            take_q <= 1'b0;
        end else if (accept_now) begin
            off_x2_q <= off_x2;
            bit_mask_q <= bit_mask(dec_bus.bit_no);
            kind_q <= dec_bus.kind;
            take_q <= branch_taken(dec_bus.kind, zero_flag_i, ovf_flag_i);
        end else if ((q_q == bbx_pkg::Q4) && (state_q == bbx_pkg::BBX_ST_EXEC)) begin
            kind_q <= bbx_pkg::BBX_NONE;
        end
    end

    // ------------------------------------------------------------
    // program counter write in Q4
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pc_load_q <= 1'b0;
            pc_target_q <= '0;
        end else if ((q_q == bbx_pkg::Q3) && (state_q == bbx_pkg::BBX_ST_EXEC) && take_q) begin
            pc_load_q <= 1'b1;
            pc_target_q <= pc_next_i + off_x2_q;
        end else begin
            pc_load_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bit set read-modify-write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mem_rd_q <= 1'b0;
            mem_addr_q <= '0;
        end else if (accept_now && (dec_bus.kind == bbx_pkg::BBX_SET_BIT)) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= file_daddr;
        end else begin
            mem_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= bbx_pkg::DATA_RESET;
        end else if (mem_rd_q) begin
            rd_data_q <= mem_rdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mem_wr_q <= 1'b0;
            mem_wdata_q <= bbx_pkg::DATA_RESET;
        end else if ((q_q == bbx_pkg::Q3) && (kind_q == bbx_pkg::BBX_SET_BIT)) begin
            mem_wr_q <= 1'b1;
            mem_wdata_q <= rd_data_q | bit_mask_q;
        end else begin
            mem_wr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status and handshake outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_we_q <= 1'b0;
        end else begin
            status_we_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            accept_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            accept_q <= accept_now && (dec_bus.kind != bbx_pkg::BBX_NONE);
            illegal_q <= accept_now && (dec_bus.kind == bbx_pkg::BBX_NONE);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            discard_q <= 1'b0;
        end else if ((q_q == bbx_pkg::Q4) && (state_q == bbx_pkg::BBX_ST_EXEC)) begin
            discard_q <= take_q;
        end else if ((q_q == bbx_pkg::Q4) && (state_q == bbx_pkg::BBX_ST_NOP)) begin
            discard_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            // one-clock pulse in Q4 of the last cycle of the instruction
            done_q <= (q_q == bbx_pkg::Q3) &&
                      (((state_q == bbx_pkg::BBX_ST_EXEC) && !take_q) || (state_q == bbx_pkg::BBX_ST_NOP));
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from its register
    // ------------------------------------------------------------
    assign q_phase_o = q_q;
    assign accept_o = accept_q;
    assign illegal_o = illegal_q;
    assign pc_load_o = pc_load_q;
    assign pc_target_o = pc_target_q;
    assign mem_rd_o = mem_rd_q;
    assign mem_wr_o = mem_wr_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign status_we_o = status_we_q;
    assign discard_o = discard_q;
    assign done_o = done_q;

endmodule
`default_nettype wire

// [src/bbx_pkg.sv]
`default_nettype none
package bbx_pkg;

    // ------------------------------------------------------------
    // quarter phases of one instruction cycle
    // ------------------------------------------------------------
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    // ------------------------------------------------------------
    // opcode patterns and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] OP_BR_NOT_ZERO = 8'he1;
    localparam logic [7:0] OP_BR_NOT_OVF = 8'he5;
    localparam logic [4:0] OP_BR_ALWAYS = 5'h1a;
    localparam logic [3:0] OP_SET_BIT = 4'h8;
    localparam int COND_OP_MSB = 15;
    localparam int COND_OP_LSB = 8;
    localparam int ALW_OP_LSB = 11;
    localparam int SET_OP_LSB = 12;
    localparam int BIT_NO_MSB = 11;
    localparam int BIT_NO_LSB = 9;
    localparam int BANK_SEL_POS = 8;
    localparam int FILE_MSB = 7;
    localparam int OFF8_MSB = 7;
    localparam int OFF11_MSB = 10;

    // ------------------------------------------------------------
    // data memory addressing
    // ------------------------------------------------------------
    localparam int DADDR_W = 12;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum {
        BBX_NONE,
        BBX_BR_NZ,
        BBX_BR_NOV,
        BBX_BR_ALW,
        BBX_SET_BIT
    } bbx_kind_type;

    typedef enum {
        BBX_ST_IDLE,
        BBX_ST_EXEC,
        BBX_ST_NOP
    } bbx_state_type;

endpackage
`default_nettype wire

// [tb/bbx_exec_sva.sv]
`default_nettype none
module bbx_exec_sva #(
    parameter int PC_W = 21
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [PC_W-1:0] pc_next_i,
    input wire logic zero_flag_i,
    input wire logic ovf_flag_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic ext_set_en_i,
    input wire logic [11:0] index_base_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [1:0] q_phase_o,
    input wire logic accept_o,
    input wire logic illegal_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_target_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic status_we_o,
    input wire logic discard_o,
    input wire logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic take, is_nz, is_nov, is_bra, is_set;
    logic [PC_W-1:0] off_q;
    logic [11:0] addr_q;
    logic [2:0] bit_q;
    assign take = q_phase_o == 2'h0 && instr_valid_i && !discard_o;
    assign is_nz = instr_i[15:8] == 8'he1;
    assign is_nov = instr_i[15:8] == 8'he5;
    assign is_bra = instr_i[15:11] == 5'h1a;
    assign is_set = instr_i[15:12] == 4'h8;
    // ------------------------------------------------------------
    // expected offset, address and bit captured at the take edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (take) begin
            off_q <= is_bra ? PC_W'(signed'(instr_i[10:0])) << 1 : PC_W'(signed'(instr_i[7:0])) << 1;
            bit_q <= instr_i[11:9];
            if (!instr_i[8] && ext_set_en_i && instr_i[7:0] <= 8'h5f) begin
                addr_q <= index_base_i + 12'(instr_i[7:0]);
            end else if (!instr_i[8]) begin
                addr_q <= {instr_i[7] ? 4'hf : 4'h0, instr_i[7:0]};
            end else begin
                addr_q <= {bank_select_register_i, instr_i[7:0]};
            end
        end
    end
    sequence s_jump;
        accept_o ##2 pc_load_o ##1 discard_o [*4];
    endsequence
    sequence s_stay;
        accept_o ##2 (done_o && !pc_load_o);
    endsequence
    sequence s_rmw;
        accept_o && mem_rd_o ##2 mem_wr_o;
    endsequence
    a_nz_jump: assert property (take && is_nz && !zero_flag_i |=> s_jump)
        else $error("nz branch not taken");
    a_nz_stay: assert property (take && is_nz && zero_flag_i |=> s_stay)
        else $error("nz branch wrongly taken");
    a_nov_jump: assert property (take && is_nov && !ovf_flag_i |=> s_jump)
        else $error("nov branch not taken");
    a_nov_stay: assert property (take && is_nov && ovf_flag_i |=> s_stay)
        else $error("nov branch wrongly taken");
    a_bra_jump: assert property (take && is_bra |=> s_jump)
        else $error("always branch timing wrong");
    a_pc_target: assert property (pc_load_o |-> pc_target_o == $past(pc_next_i) + off_q)
        else $error("branch target wrong");
    a_set_rmw: assert property (take && is_set |=> s_rmw)
        else $error("set bit phases wrong");
    a_set_addr: assert property (mem_rd_o |-> mem_addr_o == addr_q)
        else $error("set bit address wrong");
    a_set_data: assert property (mem_wr_o |-> mem_wdata_o == ($past(mem_rdata_i, 2) | (8'h01 << bit_q)))
        else $error("set bit data wrong");
    a_flags_kept: assert property (!status_we_o)
        else $error("status written");
    a_busy_refuse: assert property (discard_o && instr_valid_i && q_phase_o == 2'h0 |=> !accept_o && !illegal_o)
        else $error("word taken in nop cycle");
    a_word_unknown: assert property (take && !(is_nz || is_nov || is_bra || is_set) |=> illegal_o && !accept_o)
        else $error("unknown word accepted");
endmodule
bind bbx_exec bbx_exec_sva #(.PC_W(PC_W)) u_sva (.*);
`default_nettype wire

// [tb/bbx_exec_tb_top.sv]
`default_nettype none
module bbx_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC_W = 21;
    logic clk_sys_i, rst_i, instr_valid_i, zero_flag_i, ovf_flag_i, ext_set_en_i;
    logic [15:0] instr_i;
    logic [PC_W-1:0] pc_next_i, pc_target_o;
    logic [3:0] bank_select_register_i;
    logic [11:0] index_base_i, mem_addr_o;
    logic [7:0] mem_rdata_i, mem_wdata_o;
    logic [1:0] q_phase_o;
    logic accept_o, illegal_o, pc_load_o, mem_rd_o, mem_wr_o, status_we_o, discard_o, done_o;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    bbx_exec #(.PC_W(PC_W)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .pc_next_i(pc_next_i), .zero_flag_i(zero_flag_i), .ovf_flag_i(ovf_flag_i),
        .bank_select_register_i(bank_select_register_i), .ext_set_en_i(ext_set_en_i),
        .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i), .q_phase_o(q_phase_o), .accept_o(accept_o),
        .illegal_o(illegal_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .status_we_o(status_we_o),
        .discard_o(discard_o), .done_o(done_o));
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end
    // presents a word in q1, returns at the q2 falling edge
    task automatic present(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge clk_sys_i);
        while (q_phase_o !== 2'h0 && n < 8) begin
            @(negedge clk_sys_i);
            n++;
        end
        instr_valid_i = 1'b1;
        instr_i = w;
        @(negedge clk_sys_i);
        instr_valid_i = 1'b0;
        instr_i = ~w;
    endtask
    task automatic exec_br(input logic [15:0] w, input logic z, input logic v, input logic tk,
        input logic [PC_W-1:0] tgt);
        zero_flag_i = z;
        ovf_flag_i = v;
        present(w);
        chk(accept_o, 1'b1);
        chk(status_we_o, 1'b0);
        repeat (2) @(negedge clk_sys_i);
        chk(pc_load_o, tk);
        chk(done_o, !tk);
        if (tk) begin
            chk(pc_target_o, tgt);
            repeat (4) begin
                @(negedge clk_sys_i);
                chk(discard_o, 1'b1);
            end
            chk(done_o, 1'b1);
        end
    endtask
    task automatic exec_set(input logic [15:0] w, input logic [3:0] bank_select_register, input logic ext,
        input logic [11:0] addr, input logic [7:0] rd, input logic [7:0] wd);
        bank_select_register_i = bank_select_register;
        ext_set_en_i = ext;
        present(w);
        chk(mem_rd_o, 1'b1);
        chk(mem_addr_o, addr);
        mem_rdata_i = rd;
        @(negedge clk_sys_i);
        mem_rdata_i = ~rd;
        @(negedge clk_sys_i);
        chk(mem_wr_o, 1'b1);
        chk(mem_wdata_o, wd);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_zero_branch();
        exec_br(16'he180, 1'b0, 1'b1, 1'b1, 21'h000f00);
        exec_br(16'he17f, 1'b1, 1'b0, 1'b0, 21'h0);
        exec_br(16'he17f, 1'b0, 1'b1, 1'b1, 21'h0010fe);
    endtask
    task automatic t_ovf_branch();
        exec_br(16'he510, 1'b1, 1'b0, 1'b1, 21'h001020);
        exec_br(16'he510, 1'b0, 1'b1, 1'b0, 21'h0);
    endtask
    task automatic t_always_branch();
        exec_br(16'hd400, 1'b1, 1'b1, 1'b1, 21'h000800);
        exec_br(16'hd3ff, 1'b0, 1'b0, 1'b1, 21'h0017fe);
    endtask
    task automatic t_set_bit();
        exec_set(16'h8f25, 4'h3, 1'b1, 12'h325, 8'h0a, 8'h8a);
        exec_set(16'h8025, 4'h3, 1'b0, 12'h025, 8'h00, 8'h01);
        exec_set(16'h8690, 4'h3, 1'b0, 12'hf90, 8'hf7, 8'hff);
        exec_set(16'h8a5f, 4'h3, 1'b1, 12'h25f, 8'h00, 8'h20);
        exec_set(16'h8260, 4'h3, 1'b1, 12'h060, 8'h55, 8'h57);
    endtask
    // reset in the middle of a taken branch, then a clean branch
    task automatic t_reset_mid();
        present(16'hd000);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        @(negedge clk_sys_i);
        chk(q_phase_o, 2'h0);
        chk(pc_load_o, 1'b0);
        rst_i = 1'b0;
        exec_br(16'he17f, 1'b0, 1'b0, 1'b1, 21'h0010fe);
    endtask
    task automatic t_refuse();
        present(16'hd000);
        repeat (3) @(negedge clk_sys_i);
        instr_valid_i = 1'b1;
        instr_i = 16'he100;
        @(negedge clk_sys_i);
        instr_valid_i = 1'b0;
        chk(accept_o, 1'b0);
        chk(illegal_o, 1'b0);
        present(16'hffff);
        chk(illegal_o, 1'b1);
        chk(accept_o, 1'b0);
    endtask
    initial begin
        rst_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = 16'h0000;
        pc_next_i = 21'h001000;
        zero_flag_i = 1'b0;
        ovf_flag_i = 1'b0;
        bank_select_register_i = 4'h0;
        ext_set_en_i = 1'b0;
        index_base_i = 12'h200;
        mem_rdata_i = 8'h00;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_zero_branch();
        t_ovf_branch();
        t_always_branch();
        t_set_bit();
        t_refuse();
        t_reset_mid();
        give_verdict();
    end
endmodule
`default_nettype wire
